// ==== shared/dmem_decode_pkg.sv ====
// constants, types and layouts for the data memory bank decoder
package dmem_decode_pkg;

    // widths of the data memory path
    localparam int ADDR_W = 12;
    localparam int OPND_W = 8;
    localparam int BANK_W = 4;
    localparam int DATA_W = 8;

    // fast-access window split and the banks its halves land in
    localparam logic [OPND_W-1:0] ACCESS_SPLIT = 8'h60;
    localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;

    // general purpose ram, bottom of bank 0 upward
    localparam logic [ADDR_W-1:0] RAM_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] RAM_TOP = 12'h0ff;
    localparam int RAM_DEPTH = 256;
    localparam int RAM_IDX_W = 8;

    // special function region, top of bank 15 downward
    localparam logic [ADDR_W-1:0] SPECIAL_BASE = 12'hf60;
    localparam logic [ADDR_W-1:0] SPECIAL_TOP = 12'hfff;

    // the one register held in this block
    localparam logic [ADDR_W-1:0] BANK_SELECT_ADDR = 12'hfe0;
    localparam logic [DATA_W-1:0] BANK_SELECT_RESET = 8'h00;

    // indirect operand aliases, no storage behind them
    localparam logic [ADDR_W-1:0] ALIAS0_LO = 12'hfeb;
    localparam logic [ADDR_W-1:0] ALIAS0_HI = 12'hfef;
    localparam logic [ADDR_W-1:0] ALIAS1_LO = 12'hfe3;
    localparam logic [ADDR_W-1:0] ALIAS1_HI = 12'hfe7;
    localparam logic [ADDR_W-1:0] ALIAS2_LO = 12'hfdb;
    localparam logic [ADDR_W-1:0] ALIAS2_HI = 12'hfdf;

    // value seen at every location without storage
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;

    // where a full address lands
    typedef enum logic [1:0] {
        REGION_RAM = 2'b00,
        REGION_SPECIAL = 2'b01,
        REGION_ALIAS = 2'b10,
        REGION_NONE = 2'b11
    } region_type;

    // one data memory access from the execution logic
    typedef struct packed {
        logic [OPND_W-1:0] operand;
        logic access_sel;
        logic rd_en;
        logic wr_en;
        logic [DATA_W-1:0] wr_data;
    } mem_req_type;

    // result of the access, one cycle later
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] rd_data;
        logic done;
        region_type region;
    } mem_rsp_type;

    // whole register state of the decoder
    typedef struct packed {
        logic [DATA_W-1:0] bank_select_q;
        mem_rsp_type rsp;
    } dec_state_type;

endpackage : dmem_decode_pkg

// ==== hw/data_memory_bank_decoder.sv ====
// data memory address decoder with access window, ram and bank register
//
// How it works
// (R1) access_sel one: bank register plus operand
// (R2) access_sel zero: window map, bank ignored
// (R3) window 00h-5Fh hits bank 0 ram
// (R4) window 60h-FFh hits bank 15 top
// (R5) window access done in one cycle
// (R6) extended mode remaps lower window half
// (R7) ram never cleared or set by reset
// (R8) ram starts at 000h, grows upward
// (R9) special registers decoded F60h to FFFh
// (R10) unimplemented special registers read zero, ignore writes
// (R11) indirect alias addresses have no storage
// (R12) bank is low four bits of register
// (R13) window forces upper bits 0000 or 1111
`timescale 1ns/1ps

module data_memory_bank_decoder
    import dmem_decode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire mem_req_type req,
    input wire logic extended_instr_enable,
    input wire logic [ADDR_W-1:0] indexed_base,
    output mem_rsp_type rsp,
    output logic [DATA_W-1:0] bank_select_reg
);

    // inclusive range test on a full address
    function automatic logic in_range(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] lo,
        input logic [ADDR_W-1:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // classify a full address into its region
    function automatic region_type region_of(
        input logic [ADDR_W-1:0] a
    );
        region_type r;
        r = REGION_NONE;
        if (in_range(a, RAM_BASE, RAM_TOP)) begin
            r = REGION_RAM; // R8
        end else if (in_range(a, ALIAS0_LO, ALIAS0_HI)
                     || in_range(a, ALIAS1_LO, ALIAS1_HI)
                     || in_range(a, ALIAS2_LO, ALIAS2_HI)) begin
            r = REGION_ALIAS; // R11
        end else if (in_range(a, SPECIAL_BASE, SPECIAL_TOP)) begin
            r = REGION_SPECIAL; // R9
        end
        region_of = r;
    endfunction : region_of

    // turn operand, access bit and bank into a full address
    function automatic logic [ADDR_W-1:0] map_addr(
        input logic [OPND_W-1:0] opnd,
        input logic a_sel,
        input logic [DATA_W-1:0] bank,
        input logic ext_mode,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] m;
        m = ADDR_ZERO;
        if (a_sel) begin
            // banked form, upper register bits play no part
            m = {bank[BANK_W-1:0], opnd}; // R1 R12
        end else if (opnd < ACCESS_SPLIT) begin
            if (ext_mode) begin
                // lower half becomes an offset from the core's index base
                m = ADDR_W'(base + {{(ADDR_W-OPND_W){1'b0}}, opnd}); // R6
            end else begin
                m = {ACCESS_LOW_BANK, opnd}; // R2 R3 R13
            end
        end else begin
            m = {ACCESS_HIGH_BANK, opnd}; // R2 R4 R13
        end
        map_addr = m;
    endfunction : map_addr

    // ram storage, deliberately outside the reset state
    logic [DATA_W-1:0] general_purpose_ram [RAM_DEPTH];

    dec_state_type state_q;
    dec_state_type state_d;

    logic [ADDR_W-1:0] cur_addr;
    region_type cur_region;
    logic [RAM_IDX_W-1:0] ram_idx;
    logic ram_wr;
    logic bank_hit;

    // address decode for the access offered this cycle
    always_comb begin
        cur_addr = map_addr(req.operand, req.access_sel,
                            state_q.bank_select_q,
                            extended_instr_enable, indexed_base);
        cur_region = region_of(cur_addr);
        ram_idx = cur_addr[RAM_IDX_W-1:0];
        bank_hit = (cur_addr == BANK_SELECT_ADDR);
        ram_wr = req.wr_en && (cur_region == REGION_RAM);
    end

    // next state: bank register writes and the registered answer
    always_comb begin
        state_d = state_q;
        state_d.rsp.done = 1'b0;
        if (req.wr_en && bank_hit) begin
            state_d.bank_select_q = req.wr_data;
        end
        if (req.rd_en || req.wr_en) begin
            // every access finishes in the cycle it is offered
            state_d.rsp.done = 1'b1; // R5
            state_d.rsp.addr = cur_addr;
            state_d.rsp.region = cur_region;
            state_d.rsp.rd_data = READ_ZERO;
            if (req.rd_en) begin
                unique case (cur_region)
                    REGION_RAM: begin
                        // old contents even if written this same cycle
                        state_d.rsp.rd_data = general_purpose_ram[ram_idx];
                    end
                    REGION_SPECIAL: begin
                        if (bank_hit) begin
                            state_d.rsp.rd_data = state_q.bank_select_q;
                        end else begin
                            state_d.rsp.rd_data = READ_ZERO; // R10
                        end
                    end
                    REGION_ALIAS: begin
                        // core resolves the pointer; nothing stored here
                        state_d.rsp.rd_data = READ_ZERO; // R11
                    end
                    REGION_NONE: begin
                        state_d.rsp.rd_data = READ_ZERO; // R10
                    end
                endcase
            end
        end
    end

    // ram write port, frozen by the clock enable, no reset term
    always_ff @(posedge sys_clk) begin
        if (ce && ram_wr) begin
            general_purpose_ram[ram_idx] <= req.wr_data; // R7 R8
        end
    end

    // the whole decoder state in one register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q.bank_select_q <= BANK_SELECT_RESET;
            state_q.rsp.addr <= ADDR_ZERO;
            state_q.rsp.rd_data <= READ_ZERO;
            state_q.rsp.done <= 1'b0;
            state_q.rsp.region <= REGION_NONE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // outputs straight from the flops
    assign rsp = state_q.rsp;
    assign bank_select_reg = state_q.bank_select_q;

endmodule : data_memory_bank_decoder

// ==== dv/dmem_checker.sv ====
// port assertions for the data memory decoder
`timescale 1ns/1ps
module dmem_checker
    import dmem_decode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire mem_req_type req,
    input wire logic extended_instr_enable,
    input wire logic [ADDR_W-1:0] indexed_base,
    input wire mem_rsp_type rsp,
    input wire logic [DATA_W-1:0] bank_select_reg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // accesses taken at this edge; ce low means nothing is taken
    wire logic acc = ce && (req.rd_en || req.wr_en);
    wire logic win = acc && !req.access_sel;
    wire logic [7:0] op = req.operand;
    property p_done; acc |=> rsp.done; endproperty
    a_done: assert property (p_done) else $error("done missing");
    property p_bank; acc && req.access_sel |=> rsp.addr == {$past(bank_select_reg[3:0]), $past(op)}; endproperty
    a_bank: assert property (p_bank) else $error("banked addr");
    property p_win; win && !extended_instr_enable |=> rsp.addr == {($past(op) < 8'h60) ? 4'h0 : 4'hf, $past(op)}; endproperty
    a_win: assert property (p_win) else $error("window addr");
    property p_ext; win && extended_instr_enable && op < 8'h60 |=> rsp.addr == $past(indexed_base) + {4'h0, $past(op)}; endproperty
    a_ext: assert property (p_ext) else $error("extended addr");
    property p_bsr; rsp.done && rsp.addr == BANK_SELECT_ADDR && $past(req.wr_en) |-> bank_select_reg == $past(req.wr_data); endproperty
    a_bsr: assert property (p_bsr) else $error("bank write");
    property p_ram; rsp.done && rsp.addr <= RAM_TOP |-> rsp.region == REGION_RAM; endproperty
    a_ram: assert property (p_ram) else $error("ram region");
    property p_zero; rsp.done && rsp.addr >= SPECIAL_BASE && rsp.addr != BANK_SELECT_ADDR |-> rsp.rd_data == READ_ZERO; endproperty
    a_zero: assert property (p_zero) else $error("not zero");
    property p_alias; rsp.done && rsp.addr inside {[ALIAS0_LO:ALIAS0_HI], [ALIAS1_LO:ALIAS1_HI], [ALIAS2_LO:ALIAS2_HI]} |-> rsp.region == REGION_ALIAS; endproperty
    a_alias: assert property (p_alias) else $error("alias region");
endmodule : dmem_checker
bind data_memory_bank_decoder dmem_checker chk (.sys_clk, .rstn, .ce, .req,
    .extended_instr_enable, .indexed_base, .rsp, .bank_select_reg);

// ==== dv/exec_model.sv ====
// execution-side requester model
`timescale 1ns/1ps
module exec_model
    import dmem_decode_pkg::*;
(
    input wire logic sys_clk,
    input wire mem_rsp_type rsp,
    output mem_req_type req
);
    mem_rsp_type got;
    initial req = '0;
    // one-cycle request; the answer is taken one edge later
    task automatic access(input logic [7:0] op, input logic a, w, input logic [7:0] d);
        @(posedge sys_clk) #1;
        req = '{operand: op, access_sel: a, rd_en: !w, wr_en: w, wr_data: d};
        @(posedge sys_clk) #1;
        req.rd_en = 1'b0;
        req.wr_en = 1'b0;
        req.wr_data = ~d; // stale data must not look valid
        got = rsp;
    endtask : access
endmodule : exec_model

// ==== dv/testbench.sv ====
// self-checking testbench for the data memory decoder
`timescale 1ns/1ps
module testbench
    import dmem_decode_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic xi = 1'b0;
    logic [ADDR_W-1:0] ib = 12'h100;
    mem_req_type req;
    mem_rsp_type rsp;
    logic [DATA_W-1:0] bank_val;
    int errors = 0;
    int samples_checked = 0;
    logic [7:0] al [6] = '{8'hef, 8'heb, 8'he7, 8'he3, 8'hdf, 8'hdb};
    always #50 sys_clk = ~sys_clk;
    data_memory_bank_decoder dut (.sys_clk, .rstn, .ce, .req, .extended_instr_enable(xi),
        .indexed_base(ib), .rsp, .bank_select_reg(bank_val));
    exec_model cpu (.sys_clk, .rsp, .req);
    task automatic chk(input logic [11:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one access, then address, data, region and done are judged
    task automatic acc(input logic [7:0] op, input logic a, w, input logic [7:0] d,
        input logic [11:0] ea, input logic [7:0] ed, input region_type er);
        cpu.access(op, a, w, d);
        chk(cpu.got.addr, ea);
        chk({4'h0, cpu.got.rd_data}, {4'h0, ed});
        chk({10'h0, cpu.got.region}, {10'h0, er});
        chk({11'h0, cpu.got.done}, 12'h001);
    endtask : acc
    task automatic t_reset();
        chk({4'h0, bank_val}, 12'h000);
        chk({10'h0, rsp.region}, {10'h0, REGION_NONE});
        $display("reset test ended");
    endtask : t_reset
    // window edges, bank register, banked access through bank 3 and with upper bank register bits ignored
    task automatic t_map();
        acc(8'h05, 1'b0, 1'b1, 8'ha5, 12'h005, 8'h00, REGION_RAM);
        acc(8'h5f, 1'b0, 1'b1, 8'h3c, 12'h05f, 8'h00, REGION_RAM);
        acc(8'h60, 1'b0, 1'b0, 8'h00, 12'hf60, 8'h00, REGION_SPECIAL);
        acc(8'he0, 1'b0, 1'b1, 8'h03, 12'hfe0, 8'h00, REGION_SPECIAL);
        chk({4'h0, bank_val}, 12'h003);
        acc(8'h05, 1'b1, 1'b0, 8'h00, 12'h305, 8'h00, REGION_NONE);
        acc(8'h05, 1'b0, 1'b0, 8'h00, 12'h005, 8'ha5, REGION_RAM);
        acc(8'he0, 1'b0, 1'b1, 8'hf0, 12'hfe0, 8'h00, REGION_SPECIAL);
        acc(8'h05, 1'b1, 1'b0, 8'h00, 12'h005, 8'ha5, REGION_RAM);
        $display("map test ended");
    endtask : t_map
    // aliases and unimplemented places keep nothing written
    task automatic t_empty();
        acc(8'he0, 1'b0, 1'b1, 8'h0f, 12'hfe0, 8'h00, REGION_SPECIAL);
        foreach (al[i]) begin
            acc(al[i], 1'b1, 1'b1, 8'h5a, {4'hf, al[i]}, 8'h00, REGION_ALIAS);
            acc(al[i], 1'b1, 1'b0, 8'h00, {4'hf, al[i]}, 8'h00, REGION_ALIAS);
        end
        acc(8'h61, 1'b1, 1'b1, 8'h77, 12'hf61, 8'h00, REGION_SPECIAL);
        acc(8'h61, 1'b1, 1'b0, 8'h00, 12'hf61, 8'h00, REGION_SPECIAL);
        $display("empty test ended");
    endtask : t_empty
    // extended mode, ce hold-off, then ram survives a reset
    task automatic t_misc();
        xi = 1'b1;
        acc(8'h05, 1'b0, 1'b0, 8'h00, 12'h105, 8'h00, REGION_NONE);
        acc(8'h60, 1'b0, 1'b0, 8'h00, 12'hf60, 8'h00, REGION_SPECIAL);
        xi = 1'b0;
        // let the last done pulse drop before freezing the state
        @(posedge sys_clk) #1;
        ce = 1'b0;
        cpu.access(8'h05, 1'b0, 1'b0, 8'h00);
        chk({11'h0, cpu.got.done}, 12'h000);
        ce = 1'b1;
        rstn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rstn = 1'b1;
        acc(8'h05, 1'b0, 1'b0, 8'h00, 12'h005, 8'ha5, REGION_RAM);
        $display("misc test ended");
    endtask : t_misc
    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rstn = 1'b1;
        t_reset();
        t_map();
        t_empty();
        t_misc();
        test_done();
    end
    // whole run is near 80 cycles; a hang ends far later
    initial begin
        #200000;
        errors++;
        test_done();
    end
endmodule : testbench
